// file: pkg/ias_defs.svh
// Offsets, field positions, reset values and timing counts of the serial memory slave.
// Included by bare name from every design file that needs them.
`ifndef IAS_DEFS_SVH
`define IAS_DEFS_SVH
`define IAS_CTRL_CODE 4'h6
`define IAS_ID_RESET 8'h00
`define IAS_SN_BYTES 4'h6
`define IAS_PAGE_DEPTH 16
`define IAS_OFS_CTRL 8'h00
`define IAS_OFS_STATUS 8'h04
`define IAS_OFS_SN_LO 8'h08
`define IAS_OFS_SN_HI 8'h0C
`define IAS_OFS_PAGE_FIRST 8'h10
`define IAS_OFS_PAGE_LAST 8'h4C
`define IAS_CTRL_ACKEN 0
`define IAS_CTRL_PCLR 1
`define IAS_CTRL_RESET 1'h1
`define IAS_ST_BUSY 8
`define IAS_ST_ASSIGNED 9
`define IAS_ST_EDS 10
`define IAS_ST_COUNT 12
`define IAS_TWC_MS 10
`define IAS_CLK_MHZ 200
`define IAS_TWC_CYC (`IAS_TWC_MS * 1000 * `IAS_CLK_MHZ)
`endif

// file: pkg/ias_pkg.sv
// Types shared by the serial memory slave modules.
// Numbers live in ias_defs.svh; this package holds only the enumerations.
package ias_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_ACK = 6'h04,
    ST_TX = 6'h08,
    ST_MACK = 6'h10,
    ST_SKIP = 6'h20
  } ias_state_e;
  typedef enum logic [2:0] {
    CMD_FUSE = 3'h0,
    CMD_READ = 3'h1,
    CMD_WRITE = 3'h2,
    CMD_ASSIGN = 3'h4,
    CMD_CLEAR = 3'h6
  } ias_cmd_e;
endpackage : ias_pkg

// file: pkg/ias_line_if.sv
// Carrier for the decoded two-wire line events between the detector and the slave core.
// All signals are single-cycle pulses or levels on sys_clk.
`timescale 1ns/10ps
`default_nettype none
interface ias_line_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;
  modport det (output scl_rise, output scl_fall, output start, output stop, output sda);
  modport core (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface : ias_line_if
`default_nettype wire

// file: hw/ias_line_sync.sv
// Synchronises the serial clock and data pins and finds clock edges, start and stop.
// Assumes the link clock is far slower than sys_clk (several samples per phase).
`timescale 1ns/10ps
`default_nettype none
module ias_line_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins
  input wire logic scl_in,
  input wire logic sda_in,
  // Decoded events
  ias_line_if.det line
);
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  logic [2:0] next_scl, next_sda;

  always_comb
  begin
    next_scl = {scl_in, scl_m, scl_s};
    next_sda = {sda_in, sda_m, sda_s};
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
    end
    else
    begin
      {scl_m, scl_s, scl_p} <= next_scl;
      {sda_m, sda_s, sda_p} <= next_sda;
    end
  end

  assign line.scl_rise = scl_s & ~scl_p;
  assign line.scl_fall = ~scl_s & scl_p;
  // Data edges with the clock held high are conditions, not bits
  assign line.start = scl_s & scl_p & sda_p & ~sda_s;
  assign line.stop = scl_s & scl_p & ~sda_p & sda_s;
  assign line.sda = sda_s;
endmodule : ias_line_sync
`default_nettype wire

// file: hw/ias_page_buf.sv
// Circular page buffer that keeps the newest DEPTH bytes written over the link.
// Logical index 0 is always the oldest byte kept; DEPTH must be a power of two.
`timescale 1ns/10ps
`default_nettype none
module ias_page_buf #(
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
)(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Fill side
  input wire logic clr,
  input wire logic push,
  input wire logic [7:0] din,
  // Read side
  input wire logic [AW-1:0] bus_idx,
  input wire logic [AW-1:0] tx_idx,
  output logic [7:0] bus_q,
  output logic [7:0] tx_q,
  output logic [AW:0] count
);
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr;
  logic [AW:0] next_count;

  function automatic logic [AW-1:0] phys(input logic [AW-1:0] i);
    phys = wr_ptr - count[AW-1:0] + i;
  endfunction : phys

  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_count = count;
    if (clr)
    begin
      next_wr_ptr = '0;
      next_count = '0;
    end
    else if (push)
    begin
      next_wr_ptr = wr_ptr + 1'b1;
      // Once full the oldest byte is overwritten first
      if (count != (AW+1)'(DEPTH))
        next_count = count + 1'b1;
    end
    bus_q = mem[phys(bus_idx)];
    tx_q = mem[phys(tx_idx)];
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      count <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= 8'h00;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      count <= next_count;
      if (push && !clr)
        mem[wr_ptr] <= din;
    end
  end
endmodule : ias_page_buf
`default_nettype wire

// file: hw/ias_serial_slave.sv
// Slave front end of a software-addressed two-wire serial memory, with an Avalon-MM port.
// Assumes external open-drain pads resolve sda and the select line from the *_oe outputs.
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`include "ias_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module ias_serial_slave #(
  parameter int unsigned TWC_CYCLES = `IAS_TWC_CYC,
  // Arbitrary value, replaced per part at build time
  parameter logic [47:0] SERIAL_NO = 48'h0123_4567_89AB
)(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Two-wire link
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Open-drain select output
  output logic external_select_out,
  output logic external_select_out_oe,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import ias_pkg::*;

  ias_line_if line();
  ias_state_e st, next_st;
  ias_cmd_e cmd, next_cmd;
  logic [3:0] bitcnt, next_bitcnt, byte_idx, next_byte_idx, tx_idx, next_tx_idx;
  logic [7:0] shreg, next_shreg, dev_id, next_dev_id, new_id, next_new_id, tx_byte;
  logic oe_bit, next_oe_bit, won, next_won, mack, next_mack, wrote, next_wrote;
  logic next_sda_oe, next_eds_oe, busy, next_busy, take, code_ok;
  logic [31:0] busy_cnt, next_busy_cnt;
  logic page_push, page_clr_link, page_clr_bus;
  logic [7:0] page_bus_q, page_tx_q;
  logic [4:0] page_count;
  logic [3:0] bus_idx;
  logic acken, next_acken, next_wait;
  logic [31:0] next_rdata, status;

  ias_line_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .line(line)
  );

  ias_page_buf #(.DEPTH(`IAS_PAGE_DEPTH)) u_page (
    .sys_clk(sys_clk),
    .rst(rst),
    .clr(page_clr_link | page_clr_bus),
    .push(page_push),
    .din(shreg),
    .bus_idx(bus_idx),
    .tx_idx(tx_idx),
    .bus_q(page_bus_q),
    .tx_q(page_tx_q),
    .count(page_count)
  );

  function automatic logic cmd_known(input logic [2:0] c);
    cmd_known = (c == CMD_FUSE) || (c == CMD_READ) || (c == CMD_WRITE)
      || (c == CMD_ASSIGN) || (c == CMD_CLEAR);
  endfunction : cmd_known

  function automatic logic [7:0] sn_byte(input logic [3:0] i);
    logic [47:0] s;
    s = SERIAL_NO << (8 * i);
    sn_byte = s[47:40];
  endfunction : sn_byte

  // Acknowledge decision for the byte just shifted in
  always_comb
  begin
    code_ok = shreg[7:4] == `IAS_CTRL_CODE;
    if (byte_idx == 4'h0)
      take = code_ok && cmd_known(shreg[2:0])
        && !(shreg[2:0] == CMD_ASSIGN && dev_id != `IAS_ID_RESET);
    else if (byte_idx == 4'h1 && (cmd == CMD_READ || cmd == CMD_WRITE))
      take = shreg == dev_id;
    else
      take = 1'b1;
    take = take && acken && !busy;
    tx_byte = (cmd == CMD_ASSIGN) ? sn_byte(tx_idx) : page_tx_q;
  end

  // Link state machine
  always_comb
  begin
    next_st = st;
    next_cmd = cmd;
    next_bitcnt = bitcnt;
    next_byte_idx = byte_idx;
    next_tx_idx = tx_idx;
    next_shreg = shreg;
    next_dev_id = dev_id;
    next_new_id = new_id;
    next_oe_bit = oe_bit;
    next_won = won;
    next_mack = mack;
    next_wrote = wrote;
    next_sda_oe = sda_oe;
    next_eds_oe = external_select_out_oe;
    next_busy = busy;
    next_busy_cnt = busy_cnt;
    page_push = 1'b0;
    page_clr_link = 1'b0;
    if (busy)
    begin
      if (busy_cnt == 32'h0)
        next_busy = 1'b0;
      else
        next_busy_cnt = busy_cnt - 32'h1;
    end
    if (line.start)
    begin
      next_st = ST_RX;
      next_bitcnt = 4'h0;
      next_byte_idx = 4'h0;
      next_tx_idx = 4'h0;
      next_sda_oe = 1'b0;
      next_eds_oe = 1'b0;
      next_won = 1'b0;
      next_wrote = 1'b0;
    end
    else if (line.stop)
    begin
      next_st = ST_IDLE;
      next_sda_oe = 1'b0;
      // A stop anywhere but after the final no-ack leaves won clear
      if (cmd == CMD_ASSIGN && won)
        next_dev_id = new_id;
      if (cmd == CMD_CLEAR && byte_idx >= 4'h2)
        next_dev_id = `IAS_ID_RESET;
      if (cmd == CMD_WRITE && wrote)
      begin
        next_busy = 1'b1;
        next_busy_cnt = 32'(TWC_CYCLES - 1);
      end
    end
    else
    begin
      case (st)
        ST_RX:
          if (line.scl_rise)
          begin
            next_shreg = {shreg[6:0], line.sda};
            next_bitcnt = bitcnt + 4'h1;
          end
          else if (line.scl_fall && bitcnt == 4'h8)
          begin
            if (take)
            begin
              next_st = ST_ACK;
              next_sda_oe = 1'b1;
              if (byte_idx != 4'hF)
                next_byte_idx = byte_idx + 4'h1;
              if (byte_idx == 4'h0)
              begin
                next_cmd = ias_cmd_e'(shreg[2:0]);
                next_oe_bit = shreg[3];
              end
              if (byte_idx == 4'h1 && cmd == CMD_ASSIGN)
                next_new_id = shreg;
              // New page data starts from an empty buffer
              if (byte_idx == 4'h1 && cmd == CMD_WRITE)
                page_clr_link = 1'b1;
              if (byte_idx >= 4'h2 && cmd == CMD_WRITE)
              begin
                page_push = 1'b1;
                next_wrote = 1'b1;
              end
            end
            else
              next_st = ST_SKIP;
          end
        ST_ACK:
          if (line.scl_fall)
          begin
            next_sda_oe = 1'b0;
            next_bitcnt = 4'h0;
            if (byte_idx == 4'h2 && oe_bit && cmd != CMD_CLEAR && cmd != CMD_FUSE)
              next_eds_oe = 1'b1;
            if ((cmd == CMD_READ || cmd == CMD_ASSIGN) && byte_idx >= 4'h2)
            begin
              next_st = ST_TX;
              next_shreg = tx_byte;
              next_sda_oe = !tx_byte[7];
              next_tx_idx = tx_idx + 4'h1;
            end
            else
              next_st = ST_RX;
          end
        ST_TX:
          if (line.scl_rise)
          begin
            // A released one read back as zero means another part owns the bus
            if (cmd == CMD_ASSIGN && !sda_oe && !line.sda)
              next_st = ST_SKIP;
            next_bitcnt = bitcnt + 4'h1;
          end
          else if (line.scl_fall)
          begin
            if (bitcnt == 4'h8)
            begin
              next_sda_oe = 1'b0;
              next_st = ST_MACK;
            end
            else
            begin
              next_shreg = {shreg[6:0], 1'b0};
              next_sda_oe = !shreg[6];
            end
          end
        ST_MACK:
          if (line.scl_rise)
            next_mack = !line.sda;
          else if (line.scl_fall)
          begin
            next_bitcnt = 4'h0;
            if (mack && !(cmd == CMD_ASSIGN && tx_idx == `IAS_SN_BYTES))
            begin
              next_st = ST_TX;
              next_shreg = tx_byte;
              next_sda_oe = !tx_byte[7];
              next_tx_idx = tx_idx + 4'h1;
            end
            else
            begin
              next_st = ST_SKIP;
              next_won = cmd == CMD_ASSIGN && tx_idx == `IAS_SN_BYTES && !mack;
            end
          end
        ST_IDLE, ST_SKIP:
          next_sda_oe = 1'b0;
        default:
          next_st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st <= ST_IDLE;
      cmd <= CMD_FUSE;
      bitcnt <= 4'h0;
      byte_idx <= 4'h0;
      tx_idx <= 4'h0;
      shreg <= 8'h00;
      dev_id <= `IAS_ID_RESET;
      new_id <= `IAS_ID_RESET;
      oe_bit <= 1'b0;
      won <= 1'b0;
      mack <= 1'b0;
      wrote <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      external_select_out <= 1'b0;
      external_select_out_oe <= 1'b0;
      busy <= 1'b0;
      busy_cnt <= 32'h0;
    end
    else
    begin
      st <= next_st;
      cmd <= next_cmd;
      bitcnt <= next_bitcnt;
      byte_idx <= next_byte_idx;
      tx_idx <= next_tx_idx;
      shreg <= next_shreg;
      dev_id <= next_dev_id;
      new_id <= next_new_id;
      oe_bit <= next_oe_bit;
      won <= next_won;
      mack <= next_mack;
      wrote <= next_wrote;
      sda_oe <= next_sda_oe;
      sda_out <= 1'b0;
      external_select_out <= 1'b0;
      external_select_out_oe <= next_eds_oe;
      busy <= next_busy;
      busy_cnt <= next_busy_cnt;
    end
  end

  // Register bus: one wait cycle, then the answer
  always_comb
  begin
    bus_idx = 4'(avs_address[7:2] - 6'h04);
    status = 32'h0;
    status[7:0] = dev_id;
    status[`IAS_ST_BUSY] = busy;
    status[`IAS_ST_ASSIGNED] = dev_id != `IAS_ID_RESET;
    status[`IAS_ST_EDS] = external_select_out_oe;
    status[`IAS_ST_COUNT +: 5] = page_count;
    next_wait = avs_waitrequest;
    next_rdata = avs_readdata;
    next_acken = acken;
    page_clr_bus = 1'b0;
    if ((avs_read || avs_write) && avs_waitrequest)
    begin
      next_wait = 1'b0;
      case (avs_address)
        `IAS_OFS_CTRL: next_rdata = {31'h0, acken};
        `IAS_OFS_STATUS: next_rdata = status;
        `IAS_OFS_SN_LO: next_rdata = SERIAL_NO[31:0];
        `IAS_OFS_SN_HI: next_rdata = {16'h0, SERIAL_NO[47:32]};
        default:
          if (avs_address >= `IAS_OFS_PAGE_FIRST && avs_address <= `IAS_OFS_PAGE_LAST
              && avs_address[1:0] == 2'h0)
            next_rdata = {24'h0, page_bus_q};
          else
            next_rdata = 32'h0;
      endcase
    end
    else if (!avs_waitrequest)
    begin
      next_wait = 1'b1;
      if (avs_write && avs_address == `IAS_OFS_CTRL)
      begin
        next_acken = avs_writedata[`IAS_CTRL_ACKEN];
        page_clr_bus = avs_writedata[`IAS_CTRL_PCLR];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      acken <= `IAS_CTRL_RESET;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end
    else
    begin
      acken <= next_acken;
      avs_waitrequest <= next_wait;
      avs_readdata <= next_rdata;
    end
  end
endmodule : ias_serial_slave
`default_nettype wire

// file: test/ias_serial_slave_assertions.sv
// Concurrent checks on the pins of the serial memory slave.
// Assumes it is bound to ias_serial_slave; all checks run on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module ias_serial_slave_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Two-wire link
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Select output
  input wire logic external_select_out,
  input wire logic external_select_out_oe,
  // Avalon handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_oe_low_phase: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed while link clock high");
  a_oe_hold_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data drive moved inside a clock high phase");
  a_drive_zero: assert property (sda_oe |-> sda_out == 1'h0)
    else $error("data output drives a one");
  a_start_listens: assert property ($fell(sda_in) && scl_in |=> !sda_oe [*8])
    else $error("data driven while control byte arrives");
  a_start_frees_sel: assert property ($fell(sda_in) && scl_in |-> ##[1:8] !external_select_out_oe)
    else $error("select not released after start");
  a_sel_level: assert property (external_select_out == 1'h0)
    else $error("select output drives a one");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low longer than one cycle");
  a_wait_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without a request");

  c_ack: cover property ($rose(sda_oe));
  c_sel: cover property ($rose(external_select_out_oe));
  c_write: cover property (avs_write && !avs_waitrequest);
endmodule : ias_serial_slave_chk
`default_nettype wire

// file: test/ias_bus_master.sv
// Behavioural two-wire bus master with a 125 ns link clock.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module ias_bus_master (
  // Pins
  output logic scl,
  output logic sda_m,
  input wire logic sda_w
);
  initial
  begin
    scl = 1'h1; // Idle bus, clock stands still between frames
    sda_m = 1'h1;
  end
  task automatic bit_x(input logic b, output logic r); // One bit per pulse
    #15 sda_m = b; // Data moves only while clock low
    #47.5 scl = 1'h1;
    #31.25 r = sda_w;
    #31.25 scl = 1'h0;
  endtask : bit_x
  task automatic start;
    #15 sda_m = 1'h1;
    #47.5 scl = 1'h1;
    #31.25 sda_m = 1'h0;
    #31.25 scl = 1'h0;
  endtask : start
  task automatic stop;
    #15 sda_m = 1'h0;
    #47.5 scl = 1'h1;
    #31.25 sda_m = 1'h1;
    #31.25;
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'h1, r); // Ninth pulse for the acknowledge
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic give_ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'h1, d[i]);
    bit_x(!give_ack, r); // Withheld acknowledge ends a read
  endtask : rbyte
endmodule : ias_bus_master
`default_nettype wire

// file: test/ias_serial_slave_test.sv
// Self-checking bench: Avalon register access and two-wire frames against the slave.
// Assumes a pull-up on the data wire, resolved here from the enables; the master drives the clock.
`timescale 1ns/10ps
`default_nettype none
module ias_serial_slave_test;
  localparam logic [47:0] SN = 48'h5AC396E10F78; // Arbitrary serial value
  logic sys_clk, scl, sda_m, sda_oe, sda_out, sel_out, sel_oe, avs_waitrequest;
  logic rst = 1'h1;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  wire logic sda_w;
  int err_count = 0;
  int check_count = 0;
  assign sda_w = sda_m & (sda_oe ? sda_out : 1'h1);

  ias_serial_slave #(.TWC_CYCLES(600), .SERIAL_NO(SN)) ias_serial_slave_i (.sys_clk(sys_clk), .rst(rst),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .external_select_out(sel_out),
    .external_select_out_oe(sel_oe), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  ias_bus_master ias_bus_master_i (.scl(scl), .sda_m(sda_m), .sda_w(sda_w));

  initial
  begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("BAD %s exp %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low, takes data at that edge
  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'h0 && n < 40);
    if (avs_waitrequest !== 1'h0)
    begin
      err_count++;
      wrap_up();
    end
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask : av
  task automatic ctl(input logic [7:0] c, input logic [7:0] id, output logic a1, output logic a2);
    ias_bus_master_i.start();
    ias_bus_master_i.wbyte(c, a1);
    ias_bus_master_i.wbyte(id, a2);
  endtask : ctl

  task automatic t_regs;
    av(1'h0, 8'h04, 32'h0);
    chk("status", q, 32'h0);
    av(1'h0, 8'h00, 32'h0);
    chk("ctrl", q, 32'h1);
    av(1'h1, 8'h08, 32'hFFFFFFFF);
    av(1'h0, 8'h08, 32'h0);
    chk("sn_lo", q, SN[31:0]);
    av(1'h0, 8'h0C, 32'h0);
    chk("sn_hi", q, {16'h0, SN[47:32]});
    av(1'h0, 8'h80, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  // Every control code with the write command, then every command with the right code
  task automatic t_cmds;
    logic a1;
    logic e;
    for (int i = 0; i < 24; i++)
    begin
      e = (i < 16) ? (i == 6) : (i[2:0] inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h6});
      ias_bus_master_i.start();
      ias_bus_master_i.wbyte((i < 16) ? {i[3:0], 4'h2} : {5'h0C, i[2:0]}, a1);
      chk("ctl ack", a1, e);
      ias_bus_master_i.stop();
    end
    // With acknowledge disabled from software even a valid control byte goes unanswered
    av(1'h1, 8'h00, 32'h0);
    av(1'h0, 8'h00, 32'h0);
    chk("ctrl off", q, 32'h0);
    ias_bus_master_i.start();
    ias_bus_master_i.wbyte(8'h61, a1);
    chk("ack off", a1, 1'h0);
    ias_bus_master_i.stop();
    av(1'h1, 8'h00, 32'h1);
    $display("t_cmds done");
  endtask : t_cmds
  task automatic t_write;
    logic a1, a2;
    ctl(8'h62, 8'h00, a1, a2);
    chk("wr ids", {a1, a2}, 32'h3);
    for (int i = 0; i < 18; i++)
    begin
      ias_bus_master_i.wbyte(8'h40 + i[7:0], a1);
      chk("wr data", a1, 1'h1);
    end
    ias_bus_master_i.stop();
    ias_bus_master_i.start();
    ias_bus_master_i.wbyte(8'h62, a1);
    chk("busy ack", a1, 1'h0);
    ias_bus_master_i.stop();
    av(1'h0, 8'h04, 32'h0);
    chk("busy", q[8], 1'h1);
    for (int n = 0; n < 200 && q[8] !== 1'h0; n++)
      av(1'h0, 8'h04, 32'h0);
    chk("count", q[16:8], 9'h100);
    av(1'h0, 8'h10, 32'h0);
    chk("oldest", q, 32'h42);
    av(1'h0, 8'h4C, 32'h0);
    chk("newest", q, 32'h51);
    $display("t_write done");
  endtask : t_write
  task automatic t_read;
    logic a1, a2;
    logic [7:0] d;
    ctl(8'h61, 8'h00, a1, a2);
    chk("rd ids", {a1, a2}, 32'h3);
    ias_bus_master_i.rbyte(1'h1, d);
    chk("rd b0", d, 8'h42);
    ias_bus_master_i.rbyte(1'h0, d);
    chk("rd b1", d, 8'h43);
    #40 chk("released", sda_oe, 1'h0);
    ias_bus_master_i.stop();
    ctl(8'h61, 8'h5A, a1, a2);
    chk("id miss", {a1, a2}, 32'h2);
    ias_bus_master_i.stop();
    $display("t_read done");
  endtask : t_read
  task automatic t_assign;
    logic a1, a2;
    logic [7:0] d;
    ctl(8'h6C, 8'h3C, a1, a2);
    chk("asg ids", {a1, a2}, 32'h3);
    for (int k = 0; k < 6; k++)
    begin
      ias_bus_master_i.rbyte(k < 5, d);
      chk("serial", d, SN[47 - 8 * k -: 8]);
    end
    ias_bus_master_i.stop();
    chk("sel on", sel_oe, 1'h1);
    av(1'h0, 8'h04, 32'h0);
    chk("assigned", q[10:0], 11'h63C);
    ctl(8'h61, 8'h00, a1, a2);
    chk("old id", {a1, a2}, 32'h2);
    chk("sel off", sel_oe, 1'h0);
    ias_bus_master_i.stop();
    ctl(8'h6C, 8'h11, a1, a2);
    chk("asg again", {a1, a2}, 32'h0);
    ias_bus_master_i.stop();
    ctl(8'h66, 8'hA5, a1, a2);
    chk("clr ids", {a1, a2}, 32'h3);
    ias_bus_master_i.stop();
    av(1'h0, 8'h04, 32'h0);
    chk("cleared", q[9:0], 10'h0);
    $display("t_assign done");
  endtask : t_assign

  initial
  begin
    repeat (80000) @(posedge sys_clk);
    err_count++;
    $display("BAD watchdog exp finish seen hang");
    wrap_up();
  end
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    repeat (3) @(posedge sys_clk);
    t_regs();
    t_cmds();
    t_write();
    t_read();
    t_assign();
    wrap_up();
  end
endmodule : ias_serial_slave_test
bind ias_serial_slave ias_serial_slave_chk ias_serial_slave_chk_i (.sys_clk, .rst, .scl_in, .sda_in, .sda_out,
  .sda_oe, .external_select_out, .external_select_out_oe, .avs_read, .avs_write, .avs_waitrequest);
`default_nettype wire
